// File: rtl/aff_core.sv
// Sensor response builder and output freeze control for a dual-axis sensor
//
// Behaviour
// R1: Response bits 15:13 carry sequence tag.
// R2: Bit 12 makes the whole word odd parity.
// R3: Bits 11:10 tell sensor, self-test or exception.
// R4: Self-test active returns content code 10.
// R5: Payload right justified, zero padded above.
// R6: Exception: bits 9:8 code, 7:5 unused.
// R7: Exception bit 3 on power-down read.
// R8: Exception bit 2 on heater loop fault.
// R9: No-data bit and bits 1:0 stay zero.
// R10: Mode 00 freezes both until all four read.
// R11: Mode 01 freezes channel until other byte.
// R12: Mode 10 freezes both until other high.
// R13: Mode 11 updates outputs continuously.
// R14: 14-bit sample: high ten, low four padded.
// R15: Master reads both bytes for 14 bits.
// R16: Master sets request bit 13 for data.
// R17: Request bits 1:0 select byte register.
// R18: Mode 0 link, 16 bits, MSB first.
// R19: Control bits reset to zero.
// R20: Response tag echoes request tag.
// R21: Samples are two's complement at width.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module aff_core
    import aff_pkg::*;
(
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_reset_n,
    // Serial link pins
    input  wire logic                        i_sck,
    input  wire logic                        i_ssb_n,
    input  wire logic                        i_mosi,
    output logic                             o_miso,
    output logic                             o_miso_oe_n,
    // Filter outputs and sensor condition
    input  wire logic [aff_pkg::SAMPLE_W-1:0] i_x_sample,
    input  wire logic [aff_pkg::SAMPLE_W-1:0] i_yz_sample,
    input  wire logic                        i_heater_loop_fault,
    // Register port
    input  wire logic [aff_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [31:0]                 i_wr_data,
    input  wire logic                        i_wr_stb,
    input  wire logic                        i_rd_stb,
    output logic      [31:0]                 o_rd_data
);
    import aff_pkg::*;

    logic [2:0]              pins_s;
    logic                    sck_s, ssb_s, mosi_s;
    logic                    sck_d_q, ssb_d_q;
    logic                    sck_rise, sck_fall, ssb_fall, ssb_rise;
    aff_link_e               link_q;
    logic [WORD_W-1:0]       rx_q, tx_q, resp_q, req_q;
    logic [CNT_W-1:0]        cnt_q;
    logic [CTRL_W-1:0]       ctrl_q;
    aff_frz_e                mode;
    logic                    self_test, powered_down;
    logic                    accept, data_read;
    logic [1:0]              sel;
    logic [3:0]              rd_hit;
    logic [3:0]              flags_q, flags_d;
    logic                    frz_x_q, frz_x_d, frz_yz_q, frz_yz_d;
    logic [SAMPLE_W-1:0]     x_out_q, yz_out_q;
    logic [HI_W-1:0]         payload;
    logic [2:0]              tag;
    logic [WORD_W-1:0]       resp_d;

    // Pin synchronisers
    aff_sync #(.W(3)) u_sync (
        .i_clock   (i_clock),
        .i_reset_n (i_reset_n),
        .i_async   ({i_sck, i_ssb_n, i_mosi}),
        .o_sync    (pins_s)
    );

    assign sck_s  = pins_s[2];
    assign ssb_s  = pins_s[1];
    assign mosi_s = pins_s[0];

    // Edge history of synchronised pins
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_d_q <= 1'b0;
            ssb_d_q <= 1'b1;
        end else begin
            sck_d_q <= sck_s;
            ssb_d_q <= ssb_s;
        end
    end

    // Edge strobes
    assign sck_rise = sck_s & ~sck_d_q;
    assign sck_fall = ~sck_s & sck_d_q;
    assign ssb_fall = ~ssb_s & ssb_d_q;
    assign ssb_rise = ssb_s & ~ssb_d_q;

    // Control fields
    assign mode         = aff_frz_e'(ctrl_q[1:0]);
    assign self_test    = ctrl_q[CTRL_SELFTEST] | ctrl_q[CTRL_TCOFF];
    assign powered_down = ctrl_q[CTRL_PDOWN];

    // Link framing state
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_q <= LINK_IDLE;
        end else begin
            case (link_q)
                LINK_IDLE:  if (ssb_fall) link_q <= LINK_FRAME;
                LINK_FRAME: if (ssb_rise) link_q <= LINK_IDLE;
                default:    link_q <= LINK_IDLE;
            endcase
        end
    end

    // Receive shift and edge count, sampled on rising clock
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_q  <= '0;
            cnt_q <= '0;
        end else if (ssb_fall) begin
            cnt_q <= '0;
        end else if (link_q == LINK_FRAME && sck_rise) begin
            rx_q  <= {rx_q[WORD_W-2:0], mosi_s};                    // R18
            if (cnt_q != CNT_MAX) cnt_q <= cnt_q + 5'h01;
        end
    end

    // Transmit shift, MSB first, changed on falling clock
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_q        <= '0;
            o_miso      <= 1'b0;
            o_miso_oe_n <= 1'b1;
        end else if (ssb_fall) begin
            tx_q        <= {resp_q[WORD_W-2:0], 1'b0};              // R18
            o_miso      <= resp_q[WORD_W-1];
            o_miso_oe_n <= 1'b0;
        end else if (ssb_rise) begin
            o_miso_oe_n <= 1'b1;
        end else if (link_q == LINK_FRAME && sck_fall) begin
            o_miso      <= tx_q[WORD_W-1];                          // R18
            tx_q        <= {tx_q[WORD_W-2:0], 1'b0};
        end
    end

    // Request decode at end of a full frame
    assign accept    = ssb_rise && link_q == LINK_FRAME && cnt_q == FRAME_BITS
                       && rx_q[REQ_SEN];
    assign data_read = accept && !powered_down && !i_heater_loop_fault;
    assign sel       = rx_q[1:0];
    assign rd_hit    = 4'(4'h1 << sel);
    assign tag       = {rx_q[REQ_SQ2], rx_q[REQ_SQ1], rx_q[REQ_SQ0]}; // R20

    // Payload from the held output registers
    always_comb begin
        payload = payload_of(sel[0] ? yz_out_q : x_out_q, sel[1]);  // R14 R21
    end

    // Response word assembly
    always_comb begin
        resp_d = '0;
        resp_d[TAG_HI:TAG_LO] = tag;                                // R1
        if (powered_down || i_heater_loop_fault) begin
            resp_d[CS_HI:CS_LO]   = CS_EXCEPT;                      // R3
            resp_d[EXC_HI:EXC_LO] = EXC_SENSOR;                     // R6
            resp_d[PD_ERR_BIT]    = powered_down;                   // R7
            resp_d[HEAT_BIT]      = i_heater_loop_fault;            // R8
        end else begin
            resp_d[CS_HI:CS_LO] = self_test ? CS_SELFTEST : CS_SENSOR; // R4
            resp_d[HI_W-1:0]    = payload;                          // R5
        end
        resp_d = seal(resp_d);                                      // R2
    end

    // Response and request capture
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            resp_q <= seal(RESP_IDLE);                              // R9
            req_q  <= '0;
        end else if (ssb_rise && link_q == LINK_FRAME) begin
            req_q  <= rx_q;
            resp_q <= accept ? resp_d : seal(RESP_IDLE);
        end
    end

    // Next freeze state and byte read flags
    always_comb begin
        flags_d  = flags_q;
        frz_x_d  = frz_x_q;
        frz_yz_d = frz_yz_q;
        if (mode == FRZ_NONE) begin
            flags_d  = '0;                                          // R13
            frz_x_d  = 1'b0;
            frz_yz_d = 1'b0;
        end else if (data_read) begin
            case (mode)
                FRZ_BOTH: begin
                    flags_d = flags_q | rd_hit;
                    if (&flags_d) begin                             // R10
                        flags_d  = '0;
                        frz_x_d  = 1'b0;
                        frz_yz_d = 1'b0;
                    end else begin
                        frz_x_d  = 1'b1;
                        frz_yz_d = 1'b1;
                    end
                end
                FRZ_CHAN: begin
                    flags_d = flags_q | rd_hit;
                    if ((flags_d & MASK_X) == MASK_X) begin         // R11
                        flags_d = flags_d & ~MASK_X;
                        frz_x_d = 1'b0;
                    end else if (|(rd_hit & MASK_X)) begin
                        frz_x_d = 1'b1;
                    end
                    if ((flags_d & MASK_YZ) == MASK_YZ) begin       // R11
                        flags_d  = flags_d & ~MASK_YZ;
                        frz_yz_d = 1'b0;
                    end else if (|(rd_hit & MASK_YZ)) begin
                        frz_yz_d = 1'b1;
                    end
                end
                FRZ_HIGH: begin
                    flags_d = flags_q | (rd_hit & MASK_HI);
                    if ((flags_d & MASK_HI) == MASK_HI) begin       // R12
                        flags_d  = '0;
                        frz_x_d  = 1'b0;
                        frz_yz_d = 1'b0;
                    end else if (|(rd_hit & MASK_HI)) begin
                        frz_x_d  = 1'b1;
                        frz_yz_d = 1'b1;
                    end
                end
                default: begin
                    flags_d = flags_q;
                end
            endcase
        end
    end

    // Freeze state
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flags_q  <= '0;
            frz_x_q  <= 1'b0;
            frz_yz_q <= 1'b0;
        end else begin
            flags_q  <= flags_d;
            frz_x_q  <= frz_x_d;
            frz_yz_q <= frz_yz_d;
        end
    end

    // Channel output registers, held while frozen
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            x_out_q  <= '0;
            yz_out_q <= '0;
        end else begin
            if (!frz_x_d) x_out_q <= i_x_sample;                    // R13
            if (!frz_yz_d) yz_out_q <= i_yz_sample;
        end
    end

    // Control register writes
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= CTRL_RESET;                                   // R19
        end else if (i_wr_stb && i_addr == REG_CTRL) begin
            ctrl_q <= i_wr_data[CTRL_W-1:0];
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= '0;
        end else if (i_rd_stb) begin
            case (i_addr)
                REG_CTRL:   o_rd_data <= {27'h0, ctrl_q};
                REG_STATUS: o_rd_data <= {26'h0, frz_yz_q, frz_x_q, flags_q};
                REG_RESP:   o_rd_data <= {16'h0, resp_q};
                REG_REQ:    o_rd_data <= {16'h0, req_q};
                default:    o_rd_data <= '0;
            endcase
        end else begin
            o_rd_data <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    a_parity_odd: assert property (^resp_q == 1'b1)                      // R2
        else $error("response word parity not odd");

    a_tag_echo: assert property (accept |=>
        resp_q[TAG_HI:TAG_LO] == {$past(rx_q[REQ_SQ2]), $past(rx_q[REQ_SQ1]),
                                  $past(rx_q[REQ_SQ0])})                 // R20
        else $error("response tag differs from request tag");

    a_selftest_code: assert property (data_read && self_test |=>
        resp_q[CS_HI:CS_LO] == CS_SELFTEST)                              // R4
        else $error("self-test code missing");

    a_normal_code: assert property (data_read && !self_test |=>
        resp_q[CS_HI:CS_LO] == CS_SENSOR)                                // R3
        else $error("sensor data code missing");

    a_powerdown_exc: assert property (accept && powered_down |=>
        resp_q[CS_HI:CS_LO] == CS_EXCEPT && resp_q[PD_ERR_BIT]
        && resp_q[7:5] == 3'h0 && resp_q[EXC_HI:EXC_LO] == EXC_SENSOR)   // R7
        else $error("power-down exception malformed");

    a_heater_exc: assert property (accept && i_heater_loop_fault |=>
        resp_q[CS_HI:CS_LO] == CS_EXCEPT && resp_q[HEAT_BIT])            // R8
        else $error("heater fault bit missing");

    a_reserved_zero: assert property (resp_q[CS_HI:CS_LO] == CS_EXCEPT |->
        resp_q[4] == 1'b0 && resp_q[1:0] == 2'h0)                        // R9
        else $error("reserved exception bits set");

    a_low_pad: assert property (data_read && !sel[1] |=>
        resp_q[HI_W-1:LO_W] == 6'h00)                                    // R14
        else $error("low byte padding not zero");

    a_frozen_hold: assert property (frz_x_q && !data_read |=>
        $stable(x_out_q))                                                // R10
        else $error("frozen channel output moved");

    a_cont_update: assert property (mode == FRZ_NONE ##1 mode == FRZ_NONE |->
        x_out_q == $past(i_x_sample) && !frz_yz_q)                       // R13
        else $error("continuous mode output not following filter");

    a_miso_steady: assert property (!o_miso_oe_n && !sck_fall && !ssb_fall
        && !ssb_rise |=> $stable(o_miso))                                // R18
        else $error("data out changed away from a falling clock");

    c_sensor_read: cover property (data_read && sel == 2'h3);
    c_both_frozen: cover property (frz_x_q && frz_yz_q ##[1:400] !frz_x_q);
    c_exception:   cover property (accept && powered_down);
    c_chan_mode:   cover property (mode == FRZ_CHAN && frz_x_q && !frz_yz_q);

endmodule : aff_core
`default_nettype wire

// File: rtl/aff_pkg.sv
// Constants, types and helpers shared by the sample response and freeze block
package aff_pkg;

    // Word and sample widths
    localparam int unsigned WORD_W   = 16;
    localparam int unsigned SAMPLE_W = 14;
    localparam int unsigned HI_W     = 10;
    localparam int unsigned LO_W     = 4;
    localparam int unsigned CNT_W    = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
    localparam logic [CNT_W-1:0] CNT_MAX    = 5'h1F;

    // Response word fields
    localparam int unsigned TAG_HI      = 15;
    localparam int unsigned TAG_LO      = 13;
    localparam int unsigned PAR_BIT     = 12;
    localparam int unsigned CS_HI       = 11;
    localparam int unsigned CS_LO       = 10;
    localparam int unsigned EXC_HI      = 9;
    localparam int unsigned EXC_LO      = 8;
    localparam int unsigned PD_ERR_BIT  = 3;
    localparam int unsigned HEAT_BIT    = 2;

    // Request word fields
    localparam int unsigned REQ_SQ1 = 15;
    localparam int unsigned REQ_SQ0 = 14;
    localparam int unsigned REQ_SEN = 13;
    localparam int unsigned REQ_SQ2 = 12;

    // Content status and exception codes
    localparam logic [1:0] CS_SENSOR    = 2'h1;
    localparam logic [1:0] CS_SELFTEST  = 2'h2;
    localparam logic [1:0] CS_EXCEPT    = 2'h3;
    localparam logic [1:0] EXC_SENSOR   = 2'h1;
    localparam logic [1:0] EXC_NONSENSE = 2'h2;

    // Read flag masks: bit index equals logical channel select
    localparam logic [3:0] MASK_X  = 4'h5;
    localparam logic [3:0] MASK_YZ = 4'hA;
    localparam logic [3:0] MASK_HI = 4'hC;

    // Freeze modes
    typedef enum logic [1:0] {
        FRZ_BOTH = 2'h0,
        FRZ_CHAN = 2'h1,
        FRZ_HIGH = 2'h2,
        FRZ_NONE = 2'h3
    } aff_frz_e;

    // Link state, one-hot
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b01,
        LINK_FRAME = 2'b10
    } aff_link_e;

    // Register map and control fields
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RESP   = 8'h08;
    localparam logic [ADDR_W-1:0] REG_REQ    = 8'h0C;
    localparam int unsigned CTRL_W        = 5;
    localparam int unsigned CTRL_SELFTEST = 2;
    localparam int unsigned CTRL_TCOFF    = 3;
    localparam int unsigned CTRL_PDOWN    = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // Set the parity bit so the whole word has odd parity
    function automatic logic [WORD_W-1:0] seal(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        r = w;
        r[PAR_BIT] = 1'b0;
        r[PAR_BIT] = ~(^r);
        return r;
    endfunction : seal

    // Payload of one byte register of a sample
    function automatic logic [HI_W-1:0] payload_of(input logic [SAMPLE_W-1:0] s,
                                                   input logic hi);
        return hi ? s[SAMPLE_W-1:LO_W] : {{(HI_W-LO_W){1'b0}}, s[LO_W-1:0]};
    endfunction : payload_of

    // Response returned after reset and after any frame that was not an accepted sensor request
    localparam logic [WORD_W-1:0] RESP_IDLE = 16'h0E00;

endpackage : aff_pkg

// File: rtl/aff_sync.sv
// Two flip-flop synchroniser for link pins
`timescale 1ns/1ps
`default_nettype none
module aff_sync #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_reset_n,
    // Asynchronous inputs and their synchronised copies
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule : aff_sync
`default_nettype wire

// File: verif/aff_core_tb_top.sv
// Self-checking bench for the sample response and freeze block
`timescale 1ns/1ps
`default_nettype none
module aff_core_tb_top;
    import aff_pkg::*;
    logic        clock, reset_n, sck, ssb_n, mosi, miso, miso_oe_n, heat;
    logic        wr_stb, rd_stb, start, done, rd_pend, fx, fyz;
    logic [13:0] x_s, yz_s, x_h, yz_h;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data;
    logic [15:0] req, resp, pending;
    logic [4:0]  bits, ctrl;
    logic [3:0]  rf;
    logic [2:0]  tag;
    logic [15:0] resp_q[$];
    logic [31:0] rd_q[$];
    int          errors, num_checks, cycles, seed;

    aff_core dut (.i_clock(clock), .i_reset_n(reset_n), .i_sck(sck), .i_ssb_n(ssb_n),
        .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(miso_oe_n), .i_x_sample(x_s),
        .i_yz_sample(yz_s), .i_heater_loop_fault(heat), .i_addr(addr), .i_wr_data(wr_data),
        .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rd_data));
    aff_spi_master master (.i_clock(clock), .i_start(start), .i_req(req), .i_bits(bits),
        .o_resp(resp), .o_done(done), .i_miso(miso), .i_miso_oe_n(miso_oe_n), .o_sck(sck),
        .o_ssb_n(ssb_n), .o_mosi(mosi));

    // System clock, 100 ns
    always #50 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report

    // Watchers: oldest note against each result, plus run limit
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            final_report();
        end
        if (done) check({16'h0, resp}, {16'h0, resp_q.pop_front()});
        if (rd_pend) check(rd_data, rd_q.pop_front());
        rd_pend <= rd_stb;
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        addr   <= a;
        rd_stb <= 1'b1;
        rd_q.push_back(exp);
        @(posedge clock);
        rd_stb <= 1'b0;
        @(posedge clock);
    endtask : rd

    task automatic wr(input logic [31:0] d);
        addr    <= REG_CTRL;
        wr_data <= d;
        wr_stb  <= 1'b1;
        ctrl = d[4:0];
        if (d[1:0] == 2'h3) begin
            fx = 1'b0;
            fyz = 1'b0;
            rf = 4'h0;
        end
        @(posedge clock);
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic status;
        rd(REG_STATUS, {26'h0, fyz, fx, rf});
    endtask : status

    // Freeze bookkeeping for one served sensor read
    task automatic freeze(input logic [1:0] sel);
        rf[sel] = 1'b1;
        case (ctrl[1:0])
            2'h0: begin
                fx = 1'b1;
                fyz = 1'b1;
                if (rf == 4'hF) begin
                    fx = 1'b0;
                    fyz = 1'b0;
                    rf = 4'h0;
                end
            end
            2'h1: begin
                if (sel[0]) fyz = 1'b1;
                else fx = 1'b1;
                if ((rf & 4'h5) == 4'h5) begin
                    fx = 1'b0;
                    rf = rf & 4'hA;
                end
                if ((rf & 4'hA) == 4'hA) begin
                    fyz = 1'b0;
                    rf = rf & 4'h5;
                end
            end
            2'h2: if (sel[1]) begin
                fx = 1'b1;
                fyz = 1'b1;
                if ((rf & 4'hC) == 4'hC) begin
                    fx = 1'b0;
                    fyz = 1'b0;
                    rf = 4'h0;
                end
            end
            default: rf = 4'h0;
        endcase
    endtask : freeze

    // One frame; its answer comes back in the following frame
    task automatic frame(input logic [15:0] r, input logic [4:0] nb, input logic [13:0] xs,
                         input logic [13:0] ys, input logic h);
        logic [15:0] w;
        logic [13:0] s;
        x_s  <= xs;
        yz_s <= ys;
        heat <= h;
        resp_q.push_back(pending >> (16 - nb));
        w = 16'h0E00;
        if (nb == 5'd16 && r[13]) begin
            w = {r[12], r[15], r[14], 13'h0};
            if (ctrl[4] || h) begin
                w[11:8] = 4'hD;
                w[3] = ctrl[4];
                w[2] = h;
            end else begin
                x_h = fx ? x_h : xs;
                yz_h = fyz ? yz_h : ys;
                s = r[0] ? yz_h : x_h;
                w[11:10] = (ctrl[2] | ctrl[3]) ? 2'h2 : 2'h1;
                w[9:0] = r[1] ? s[13:4] : {6'h0, s[3:0]};
                freeze(r[1:0]);
            end
        end
        w[12] = ~^w;
        pending = w;
        req   <= r;
        bits  <= nb;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        while (done !== 1'b1) @(posedge clock);
        @(posedge clock);
    endtask : frame

    function automatic logic [15:0] rq(input logic [1:0] sel);
        tag = tag + 3'h1;
        return {tag[1], tag[0], 1'b1, tag[2], 10'h000, sel};
    endfunction : rq

    task automatic fr(input logic [1:0] sel, input logic h = 1'b0);
        frame(rq(sel), 5'd16, 14'($urandom), 14'($urandom), h);
    endtask : fr

    initial begin
        seed = $urandom(32'hABB83560);
        {clock, reset_n, heat, wr_stb, rd_stb, start, rd_pend, fx, fyz} = '0;
        {x_s, yz_s, x_h, yz_h, addr, wr_data, req, ctrl, rf, tag} = '0;
        bits = 5'd16;
        pending = 16'h0E00;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(REG_CTRL, 32'h0);
        rd(8'h10, 32'h0);
        status();
        // Mode 00: freeze both until all four bytes read
        frame(rq(2'h2), 5'd16, 14'h3FFF, 14'h2000, 1'b0);
        fr(2'h0);
        status();
        fr(2'h3);
        fr(2'h1);
        status();
        // Mode 01: per channel freeze
        wr(32'h1);
        fr(2'h0);
        fr(2'h3);
        status();
        fr(2'h2);
        fr(2'h1);
        status();
        // Mode 10: high bytes only
        wr(32'h2);
        fr(2'h0);
        fr(2'h2);
        fr(2'h2);
        fr(2'h1);
        fr(2'h3);
        fr(2'h0);
        // Mode 11, self-test, temp-comp off, exceptions
        wr(32'h3);
        fr(2'h2);
        fr(2'h2);
        wr(32'h7);
        fr(2'h1);
        wr(32'hB);
        fr(2'h0);
        fr(2'h2, 1'b1);
        wr(32'h13);
        fr(2'h3);
        fr(2'h0, 1'b1);
        wr(32'h0);
        // Refused frames: control target, short count
        frame(16'h8000, 5'd16, 14'h0, 14'h0, 1'b0);
        frame(rq(2'h2), 5'd15, 14'h1555, 14'h2AAA, 1'b0);
        fr(2'h2);
        fr(2'h3);
        final_report();
    end
endmodule : aff_core_tb_top
`default_nettype wire

// File: verif/aff_spi_master.sv
// Serial bus master model issuing sensor data requests
`timescale 1ns/1ps
`default_nettype none
module aff_spi_master (
    // Clock
    input  wire logic        i_clock,
    // Request from bench
    input  wire logic        i_start,
    input  wire logic [15:0] i_req,
    input  wire logic [4:0]  i_bits,
    output var  logic [15:0] o_resp,
    output var  logic        o_done,
    // Link pins
    input  wire logic        i_miso,
    input  wire logic        i_miso_oe_n,
    output var  logic        o_sck,
    output var  logic        o_ssb_n,
    output var  logic        o_mosi
);
    logic [15:0] rx;
    logic        last;
    logic        line;

    // Released line shows the inverse of its last driven level
    assign line = i_miso_oe_n ? ~last : i_miso;
    always @(posedge i_clock) if (!i_miso_oe_n) last <= i_miso;

    // Idle pins, clock stands low between frames
    initial begin
        o_sck   = 1'b0;
        o_ssb_n = 1'b1;
        o_mosi  = 1'b0;
        o_done  = 1'b0;
        o_resp  = 16'h0000;
        last    = 1'b0;
    end

    // One frame: select, mode 0 clocks at 8 system clocks each, MSB first
    always @(posedge i_clock) begin
        if (i_start) begin
            rx = 16'h0000;
            o_ssb_n <= 1'b0;
            o_mosi  <= i_req[15];
            repeat (8) @(posedge i_clock);
            for (int i = 0; i < i_bits; i++) begin
                o_sck <= 1'b1;
                rx = {rx[14:0], line};
                repeat (4) @(posedge i_clock);
                o_sck  <= 1'b0;
                o_mosi <= i_req[(14 - i) & 15];
                repeat (4) @(posedge i_clock);
            end
            o_ssb_n <= 1'b1;
            o_mosi  <= ~o_mosi;
            repeat (8) @(posedge i_clock);
            o_resp <= rx;
            o_done <= 1'b1;
            @(posedge i_clock);
            o_done <= 1'b0;
        end
    end
endmodule : aff_spi_master
`default_nettype wire
